// >>> hdl/psd_decode.sv
// decoder and sequencer for program and system control opcodes
// assumes instruction memory and wake logic on the same clock as i_clk
//
// Contract
// - call pushes pc+1, loads low byte from literal, clears bit 8, page bits on top, three cycles.
// - branch loads nine literal bits and page bits on top, three cycles.
// - subroutine exit reloads pc from the stack top in three cycles with no flag change.
// - cross page exit copies stack bits 11:9 to page bits and reloads the whole pc.
// - irq exit restores w, status, file select, mode and pc from shadows in three cycles, keeping timeout and powerdown bits.
// - irq exit with timer adjust also adds w to the realtime counter.
// - literal exit loads w with the literal and pc from the stack top in three cycles.
// - bank select copies its three bit operand into file select bits 6:4 in one cycle.
// - table fetch reads the word at mode:w back into mode:w in four cycles.
// - page select copies its operand into status bits 7:5 in one cycle.
// - powerdown clears the watchdog, sets the timeout flag and stops the oscillator.
// - powerdown clears the powerdown flag and clears the prescaler when it serves the watchdog.
// - the all zero idle opcode takes one cycle and changes nothing.
// - the clear carry alias decodes as clearing bit 0 of status at file address 03.
// - a bit test skip on the status or pc byte costs one cycle when false and two when true, dropping the next word.
// - the skip alias tests pc bit 0 at file address 02 and always costs two cycles.
module psd_decode
    import psd_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_sys_rst,
    input wire logic i_ce,
    input wire logic [11:0] i_instr,
    input wire logic i_instr_valid,
    input wire logic [11:0] i_table_data,
    input wire logic i_irq_take,
    input wire logic i_wake,
    input wire logic i_psa_wdt,
    output logic [11:0] o_pc,
    output logic [7:0] o_w,
    output logic [7:0] o_status,
    output logic [7:0] o_fsr,
    output logic [3:0] o_mode,
    output logic [7:0] o_realtime_counter_reg,
    output logic [7:0] o_wdt,
    output logic o_ready,
    output logic o_flush,
    output logic o_table_req,
    output logic [11:0] o_table_addr,
    output logic o_osc_stop,
    output logic o_prescaler_clr
);
    psd_state_e state_ff, nxt_state;
    logic [2:0] cnt_ff, nxt_cnt;
    logic [11:0] pc_ff, nxt_pc;
    logic [7:0] w_ff, nxt_w, status_ff, nxt_status, fsr_ff, nxt_fsr;
    logic [3:0] mode_ff, nxt_mode;
    logic [7:0] realtime_counter_reg_ff, nxt_realtime_counter_reg, wdt_ff, nxt_wdt;
    logic [11:0] sh_pc_ff, nxt_sh_pc;
    logic [7:0] sh_w_ff, nxt_sh_w, sh_status_ff, nxt_sh_status;
    logic [7:0] sh_fsr_ff, nxt_sh_fsr;
    logic [3:0] sh_mode_ff, nxt_sh_mode;
    logic ready_ff, nxt_ready, flush_ff, nxt_flush;
    logic treq_ff, nxt_treq, osc_stop_ff, nxt_osc_stop;
    logic pclr_ff, nxt_pclr;
    logic [11:0] taddr_ff, nxt_taddr;
    logic [11:0] stack_ff [STACK_DEPTH];
    logic [2:0] sp_ff, nxt_sp;
    logic push_en;
    logic [11:0] push_data, stack_top;
    logic take;
    logic [2:0] cost;

    function automatic logic bit_at(input logic [7:0] v, input logic [2:0] b);
        bit_at = v[b];
    endfunction

    assign take = ready_ff && i_instr_valid && !i_irq_take;
    assign stack_top = stack_ff[sp_ff - 3'h1];

    always_comb begin
        cost = CYC_ONE;
        nxt_state = state_ff;
        nxt_cnt = cnt_ff;
        nxt_pc = pc_ff;
        nxt_w = w_ff;
        nxt_status = status_ff;
        nxt_fsr = fsr_ff;
        nxt_mode = mode_ff;
        nxt_realtime_counter_reg = realtime_counter_reg_ff;
        nxt_wdt = wdt_ff + 8'h01;
        nxt_sh_pc = sh_pc_ff;
        nxt_sh_w = sh_w_ff;
        nxt_sh_status = sh_status_ff;
        nxt_sh_fsr = sh_fsr_ff;
        nxt_sh_mode = sh_mode_ff;
        nxt_flush = 1'b0;
        nxt_treq = 1'b0;
        nxt_taddr = taddr_ff;
        nxt_osc_stop = osc_stop_ff;
        nxt_pclr = 1'b0;
        nxt_sp = sp_ff;
        push_en = 1'b0;
        push_data = pc_ff + 12'h001;
        unique case (state_ff)
            PSD_RUN: begin
                if (i_irq_take) begin
                    nxt_sh_pc = pc_ff;
                    nxt_sh_w = w_ff;
                    nxt_sh_status = status_ff;
                    nxt_sh_fsr = fsr_ff;
                    nxt_sh_mode = mode_ff;
                    nxt_pc = IRQ_VECTOR;
                    cost = CYC_FLOW;
                end else if (i_instr_valid) begin
                    nxt_pc = pc_ff + 12'h001;
                    if (i_instr[11:8] == OP_CALL_HI) begin
                        push_en = 1'b1;
                        nxt_sp = sp_ff + 3'h1;
                        nxt_pc = {status_ff[ST_PAGE_HI:ST_PAGE_LO], 1'b0,
                                  i_instr[7:0]};
                        cost = CYC_FLOW;
                    end else if (i_instr[11:9] == OP_BRANCH_HI) begin
                        nxt_pc = {status_ff[ST_PAGE_HI:ST_PAGE_LO],
                                  i_instr[8:0]};
                        cost = CYC_FLOW;
                    end else if (i_instr[11:8] == OP_LIT_EXIT_HI) begin
                        nxt_w = i_instr[7:0];
                        nxt_pc = stack_top;
                        nxt_sp = sp_ff - 3'h1;
                        cost = CYC_FLOW;
                    end else if (i_instr == OP_SUB_EXIT ||
                                 i_instr == OP_XPAGE_EXIT) begin
                        nxt_pc = stack_top;
                        nxt_sp = sp_ff - 3'h1;
                        if (i_instr == OP_XPAGE_EXIT)
                            nxt_status[ST_PAGE_HI:ST_PAGE_LO] =
                                stack_top[11:9];
                        cost = CYC_FLOW;
                    end else if (i_instr == OP_IRQ_EXIT ||
                                 i_instr == OP_IRQ_EXIT_TA) begin
                        nxt_pc = sh_pc_ff;
                        nxt_w = sh_w_ff;
                        nxt_fsr = sh_fsr_ff;
                        nxt_mode = sh_mode_ff;
                        nxt_status = sh_status_ff;
                        nxt_status[ST_TIMEOUT] = status_ff[ST_TIMEOUT];
                        nxt_status[ST_POWERDOWN] = status_ff[ST_POWERDOWN];
                        if (i_instr == OP_IRQ_EXIT_TA)
                            nxt_realtime_counter_reg = realtime_counter_reg_ff + w_ff;
                        cost = CYC_FLOW;
                    end else if (i_instr[11:3] == OP_BANK_HI) begin
                        nxt_fsr[FSR_BANK_HI:FSR_BANK_LO] =
                            i_instr[2:0];
                    end else if (i_instr[11:3] == OP_PAGE_HI) begin
                        nxt_status[ST_PAGE_HI:ST_PAGE_LO] =
                            i_instr[2:0];
                    end else if (i_instr == OP_TABLE_FETCH) begin
                        nxt_treq = 1'b1;
                        nxt_taddr = {mode_ff, w_ff};
                        cost = CYC_TABLE;
                    end else if (i_instr == OP_POWERDOWN) begin
                        nxt_wdt = 8'h00;
                        nxt_status[ST_TIMEOUT] = 1'b1;
                        nxt_osc_stop = 1'b1;
                        nxt_status[ST_POWERDOWN] = 1'b0;
                        nxt_pclr = i_psa_wdt;
                    end else if (i_instr == OP_MOV_PC_W ||
                                 i_instr == OP_ADD_PC_W) begin
                        nxt_pc = {status_ff[ST_PAGE_HI:ST_PAGE_LO], 1'b0,
                                  (i_instr == OP_ADD_PC_W) ?
                                  pc_ff[7:0] + w_ff : w_ff};
                        cost = CYC_FLOW;
                    end else if (i_instr[11:10] == 2'b01 &&
                                 (i_instr[4:0] == FA_STATUS ||
                                  i_instr[4:0] == FA_PC)) begin
                        // bit ops here only reach the pc and status bytes
                        if (i_instr[11:9] == 3'b010) begin
                            if (i_instr[4:0] == FA_STATUS)
                                nxt_status[i_instr[7:5]] =
                                    i_instr[8];
                            else begin
                                nxt_pc = {status_ff[ST_PAGE_HI:ST_PAGE_LO],
                                          1'b0, pc_ff[7:0]};
                                nxt_pc[i_instr[7:5]] = i_instr[8];
                                cost = CYC_FLOW;
                            end
                        end else if ((i_instr[4:0] == FA_STATUS ?
                                      bit_at(status_ff, i_instr[7:5]) :
                                      bit_at(pc_ff[7:0], i_instr[7:5]))
                                     == i_instr[8]) begin
                            nxt_pc = pc_ff + 12'h002;
                            cost = CYC_SKIP;
                        end
                    end
                    // the idle opcode falls through every arm
                end
                if (i_instr_valid || i_irq_take) begin
                    if (take && i_instr == OP_POWERDOWN)
                        nxt_state = PSD_SLEEP;
                    else if (cost == CYC_TABLE) begin
                        nxt_state = PSD_TABLE;
                        nxt_flush = 1'b1;
                    end else if (cost != CYC_ONE) begin
                        nxt_state = PSD_WAIT;
                        nxt_cnt = cost - 3'h2;
                        nxt_flush = 1'b1;
                    end
                end
            end
            PSD_WAIT: begin
                if (cnt_ff == 3'h0)
                    nxt_state = PSD_RUN;
                else
                    nxt_cnt = cnt_ff - 3'h1;
            end
            PSD_TABLE: begin
                nxt_mode = i_table_data[11:8];
                nxt_w = i_table_data[7:0];
                nxt_state = PSD_WAIT;
                nxt_cnt = TABLE_TAIL;
            end
            PSD_SLEEP: begin
                if (i_wake) begin
                    nxt_state = PSD_RUN;
                    nxt_osc_stop = 1'b0;
                end
            end
        endcase
        nxt_ready = (nxt_state == PSD_RUN);
    end

    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            state_ff <= PSD_RUN;
            cnt_ff <= 3'h0;
            pc_ff <= RST_PC;
            w_ff <= RST_BYTE;
            status_ff <= RST_STATUS;
            fsr_ff <= RST_BYTE;
            mode_ff <= RST_MODE;
            realtime_counter_reg_ff <= RST_BYTE;
            wdt_ff <= RST_BYTE;
            sh_pc_ff <= RST_PC;
            sh_w_ff <= RST_BYTE;
            sh_status_ff <= RST_STATUS;
            sh_fsr_ff <= RST_BYTE;
            sh_mode_ff <= RST_MODE;
            ready_ff <= 1'b1;
            flush_ff <= 1'b0;
            treq_ff <= 1'b0;
            taddr_ff <= RST_PC;
            osc_stop_ff <= 1'b0;
            pclr_ff <= 1'b0;
            sp_ff <= 3'h0;
        end else if (i_ce) begin
            state_ff <= nxt_state;
            cnt_ff <= nxt_cnt;
            pc_ff <= nxt_pc;
            w_ff <= nxt_w;
            status_ff <= nxt_status;
            fsr_ff <= nxt_fsr;
            mode_ff <= nxt_mode;
            realtime_counter_reg_ff <= nxt_realtime_counter_reg;
            wdt_ff <= nxt_wdt;
            sh_pc_ff <= nxt_sh_pc;
            sh_w_ff <= nxt_sh_w;
            sh_status_ff <= nxt_sh_status;
            sh_fsr_ff <= nxt_sh_fsr;
            sh_mode_ff <= nxt_sh_mode;
            ready_ff <= nxt_ready;
            flush_ff <= nxt_flush;
            treq_ff <= nxt_treq;
            taddr_ff <= nxt_taddr;
            osc_stop_ff <= nxt_osc_stop;
            pclr_ff <= nxt_pclr;
            sp_ff <= nxt_sp;
        end
    end

    // stack contents carry no reset; the pointer alone defines them
    always_ff @(posedge i_clk) begin
        if (i_ce && !i_sys_rst && push_en)
            stack_ff[sp_ff] <= push_data;
    end

    assign o_pc = pc_ff;
    assign o_w = w_ff;
    assign o_status = status_ff;
    assign o_fsr = fsr_ff;
    assign o_mode = mode_ff;
    assign o_realtime_counter_reg = realtime_counter_reg_ff;
    assign o_wdt = wdt_ff;
    assign o_ready = ready_ff;
    assign o_flush = flush_ff;
    assign o_table_req = treq_ff;
    assign o_table_addr = taddr_ff;
    assign o_osc_stop = osc_stop_ff;
    assign o_prescaler_clr = pclr_ff;

    logic tk;
    assign tk = take && i_ce;

    call_target_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        tk && i_instr[11:8] == OP_CALL_HI |=> pc_ff == {$past(status_ff[7:5]),
        1'b0, $past(i_instr[7:0])} && stack_top == $past(pc_ff) + 12'h001)
        else $error("call target or push wrong");
    branch_time_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        tk && i_instr[11:9] == OP_BRANCH_HI |=>
        !ready_ff ##1 !ready_ff ##1 ready_ff)
        else $error("branch not three cycles");
    sub_exit_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        tk && i_instr == OP_SUB_EXIT |=> pc_ff == $past(stack_top)
        && status_ff == $past(status_ff))
        else $error("subroutine exit wrong");
    xpage_exit_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        tk && i_instr == OP_XPAGE_EXIT |=>
        status_ff[7:5] == $past(stack_top[11:9]))
        else $error("cross page bits wrong");
    irq_keep_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        tk && i_instr == OP_IRQ_EXIT |=> pc_ff == $past(sh_pc_ff) &&
        status_ff[4:3] == $past(status_ff[4:3]) && w_ff == $past(sh_w_ff))
        else $error("irq exit restore wrong");
    realtime_counter_reg_adjust_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        tk && i_instr == OP_IRQ_EXIT_TA |=>
        realtime_counter_reg_ff == $past(realtime_counter_reg_ff) + $past(w_ff))
        else $error("realtime counter not adjusted");
    bank_load_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        tk && i_instr[11:3] == OP_BANK_HI |=>
        fsr_ff[6:4] == $past(i_instr[2:0]) && ready_ff)
        else $error("bank select wrong");
    table_back_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        tk && i_instr == OP_TABLE_FETCH |=> o_table_req &&
        o_table_addr == {$past(mode_ff), $past(w_ff)} && !ready_ff)
        else $error("table fetch address wrong");
    powerdown_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        tk && i_instr == OP_POWERDOWN |=> wdt_ff == 8'h00 && osc_stop_ff
        && status_ff[4] && !status_ff[3] && pclr_ff == $past(i_psa_wdt))
        else $error("powerdown effects wrong");
    idle_quiet_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        tk && i_instr == OP_IDLE |=> ready_ff && !flush_ff &&
        pc_ff == $past(pc_ff) + 12'h001 && status_ff == $past(status_ff))
        else $error("idle opcode changed state");
    skip_cost_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        tk && i_instr[11:9] == 3'b011 && i_instr[4:0] == FA_PC &&
        pc_ff[i_instr[7:5]] == i_instr[8] |=> !ready_ff &&
        pc_ff == $past(pc_ff) + 12'h002)
        else $error("skip not taken");
endmodule

// >>> hdl/psd_pkg.sv
// constants for the program and system control decoder
// assumes twelve-bit opcodes and a single instruction clock
package psd_pkg;
    localparam logic [11:0] OP_IDLE = 12'h000;
    localparam logic [11:0] OP_POWERDOWN = 12'h003;
    localparam logic [11:0] OP_SUB_EXIT = 12'h00C;
    localparam logic [11:0] OP_XPAGE_EXIT = 12'h00D;
    localparam logic [11:0] OP_IRQ_EXIT = 12'h00E;
    localparam logic [11:0] OP_IRQ_EXIT_TA = 12'h00F;
    localparam logic [11:0] OP_TABLE_FETCH = 12'h041;
    localparam logic [11:0] OP_MOV_PC_W = 12'h022;
    localparam logic [11:0] OP_ADD_PC_W = 12'h1E2;
    localparam logic [8:0] OP_PAGE_HI = 9'h002;
    localparam logic [8:0] OP_BANK_HI = 9'h003;
    localparam logic [3:0] OP_CALL_HI = 4'h9;
    localparam logic [3:0] OP_LIT_EXIT_HI = 4'h8;
    localparam logic [2:0] OP_BRANCH_HI = 3'h5;
    localparam logic [3:0] OP_CLRB_HI = 4'h4;
    localparam logic [3:0] OP_SETB_HI = 4'h5;
    localparam logic [3:0] OP_SNB_HI = 4'h6;
    localparam logic [3:0] OP_SB_HI = 4'h7;
    localparam logic [4:0] FA_PC = 5'h02;
    localparam logic [4:0] FA_STATUS = 5'h03;
    localparam int ST_CARRY = 0;
    localparam int ST_ZERO = 2;
    localparam int ST_POWERDOWN = 3;
    localparam int ST_TIMEOUT = 4;
    localparam int ST_PAGE_LO = 5;
    localparam int ST_PAGE_HI = 7;
    localparam int FSR_BANK_LO = 4;
    localparam int FSR_BANK_HI = 6;
    localparam logic [2:0] CYC_ONE = 3'h1;
    localparam logic [2:0] CYC_SKIP = 3'h2;
    localparam logic [2:0] CYC_FLOW = 3'h3;
    localparam logic [2:0] CYC_TABLE = 3'h4;
    localparam logic [2:0] TABLE_TAIL = 3'h1;
    // arbitrary entry address for interrupts
    localparam logic [11:0] IRQ_VECTOR = 12'h000;
    localparam logic [7:0] RST_STATUS = 8'h18;
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [11:0] RST_PC = 12'h000;
    localparam logic [3:0] RST_MODE = 4'h0;
    localparam int STACK_DEPTH = 8;
    typedef enum logic [1:0] {
        PSD_RUN = 2'b00,
        PSD_WAIT = 2'b01,
        PSD_TABLE = 2'b10,
        PSD_SLEEP = 2'b11
    } psd_state_e;
endpackage

// >>> tb/program_system_control_decode_test.sv
// self-checking bench for the program and system control decoder
// assumes the imem model; expectations come from a reference kept here
module program_system_control_decode_test;
    import psd_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic valid = 1'b0;
    logic irq = 1'b0;
    logic wake = 1'b0;
    logic psa = 1'b0;
    logic ce = 1'b1;
    logic [7:0] wdt_hold;
    logic [11:0] instr, tdata, pc, taddr, e_pc, s_pc;
    logic [7:0] w, st, file_select_reg, realtime_counter_reg, wdt, e_w, e_st, e_fsr, e_realtime_counter_reg;
    logic [7:0] s_w, s_st, s_fsr;
    logic [3:0] mode, e_mode, s_mode;
    logic ivalid, ready, flush, treq, osc, pclr;
    logic [11:0] stk [$];
    int bad_count = 0;
    int comparisons = 0;
    int seed = 32615;
    always #2 clk = ~clk;
    psd_imem_model u_mem (.i_clk(clk), .i_addr(pc), .i_valid(valid),
        .i_table_req(treq), .i_table_addr(taddr), .o_instr(instr),
        .o_instr_valid(ivalid), .o_table_data(tdata));
    psd_decode u_dut (.i_clk(clk), .i_sys_rst(rst), .i_ce(ce),
        .i_instr(instr), .i_instr_valid(ivalid), .i_table_data(tdata),
        .i_irq_take(irq), .i_wake(wake), .i_psa_wdt(psa), .o_pc(pc),
        .o_w(w), .o_status(st), .o_fsr(file_select_reg), .o_mode(mode), .o_realtime_counter_reg(realtime_counter_reg),
        .o_wdt(wdt), .o_ready(ready), .o_flush(flush), .o_table_req(treq),
        .o_table_addr(taddr), .o_osc_stop(osc), .o_prescaler_clr(pclr));
    task automatic chk(input string name, input logic [11:0] exp,
                       input logic [11:0] got);
        comparisons++;
        if (got !== exp) begin
            bad_count++;
            $display("ERROR %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic print_verdict();
        $display("counts: %0d compared, %0d mismatched", comparisons,
                 bad_count);
        if (bad_count == 0 && comparisons > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    // reference step: updates the expected state, returns the cycle cost
    task automatic ref_step(input logic [11:0] op, output int cost);
        logic [7:0] bv;
        bv = (op[4:0] == FA_PC) ? e_pc[7:0] : e_st;
        cost = 1;
        e_pc = e_pc + 12'h001;
        if (op == OP_SUB_EXIT || op == OP_XPAGE_EXIT) begin
            if (op[0]) e_st[7:5] = stk[$][11:9];
            e_pc = stk.pop_back();
            cost = 3;
        end else if (op == OP_IRQ_EXIT || op == OP_IRQ_EXIT_TA) begin
            if (op[0]) e_realtime_counter_reg = e_realtime_counter_reg + e_w;
            e_w = s_w;
            e_st = {s_st[7:5], e_st[4:3], s_st[2:0]};
            e_fsr = s_fsr;
            e_mode = s_mode;
            e_pc = s_pc;
            cost = 3;
        end else if (op == OP_TABLE_FETCH) begin
            {e_mode, e_w} = u_mem.mem[{e_mode, e_w}];
            cost = 4;
        end else if (op == OP_MOV_PC_W) begin
            e_pc = {e_st[7:5], 1'b0, e_w};
            cost = 3;
        end else if (op == OP_ADD_PC_W ||
                     (op[11:9] == 3'h2 && op[4:0] == FA_PC)) begin
            // pc writes start from the writing opcode's own address
            e_pc = {e_st[7:5], 1'b0, 8'(e_pc[7:0] - 8'h01)};
            if (!op[10]) e_pc[7:0] = e_pc[7:0] + e_w;
            else e_pc[op[7:5]] = op[8];
            cost = 3;
        end else if (op[11:4] == 8'h01) begin
            if (op[3]) e_fsr[6:4] = op[2:0];
            else e_st[7:5] = op[2:0];
        end else if (op[11:8] == OP_CALL_HI) begin
            stk.push_back(e_pc);
            e_pc = {e_st[7:5], 1'b0, op[7:0]};
            cost = 3;
        end else if (op[11:8] == OP_LIT_EXIT_HI) begin
            e_w = op[7:0];
            e_pc = stk.pop_back();
            cost = 3;
        end else if (op[11:9] == OP_BRANCH_HI) begin
            e_pc = {e_st[7:5], op[8:0]};
            cost = 3;
        end else if (op[11:9] == 3'h2) begin
            e_st[op[7:5]] = op[8];
        end else if (op[11:9] == 3'h3 && bv[op[7:5]] == op[8]) begin
            e_pc = e_pc + 12'h001;
            cost = 2;
        end
    endtask
    task automatic exec(input logic [11:0] op);
        int cost;
        int n;
        logic [11:0] ta;
        ta = {e_mode, e_w};
        u_mem.mem[e_pc] = op;
        ref_step(op, cost);
        valid = 1'b1;
        @(negedge clk);
        valid = 1'b0;
        if (cost == 3) chk("flush", 12'h001, 12'(flush));
        if (cost == 4) chk("table addr", ta, treq ? taddr : 12'hFFF);
        n = 1;
        while (ready !== 1'b1 && n < 10) begin
            n++;
            @(negedge clk);
        end
        chk("cycles", 12'(cost), 12'(n));
        chk("pc", e_pc, pc);
        chk("w", 12'(e_w), 12'(w));
        chk("status", 12'(e_st), 12'(st));
        chk("fsr", 12'(e_fsr), 12'(file_select_reg));
        chk("mode", 12'(e_mode), 12'(mode));
        chk("realtime_counter_reg", 12'(e_realtime_counter_reg), 12'(realtime_counter_reg));
    endtask
    task automatic sleep_wake(input logic pv);
        psa = pv;
        u_mem.mem[e_pc] = OP_POWERDOWN;
        e_pc = e_pc + 12'h001;
        e_st[ST_TIMEOUT] = 1'b1;
        e_st[ST_POWERDOWN] = 1'b0;
        valid = 1'b1;
        @(negedge clk);
        valid = 1'b0;
        chk("wdt", 12'h000, 12'(wdt));
        chk("osc stop", 12'h001, 12'(osc));
        chk("prescaler clr", 12'(pv), 12'(pclr));
        repeat (5) @(negedge clk);
        chk("sleep ready", 12'h000, 12'(ready));
        wake = 1'b1;
        @(negedge clk);
        wake = 1'b0;
        chk("osc on", 12'h000, 12'(osc));
        chk("status", 12'(e_st), 12'(st));
        chk("pc", e_pc, pc);
        $display("test sleep done");
    endtask
    task automatic irq_enter();
        s_pc = e_pc;
        s_w = e_w;
        s_st = e_st;
        s_fsr = e_fsr;
        s_mode = e_mode;
        e_pc = IRQ_VECTOR;
        irq = 1'b1;
        @(negedge clk);
        irq = 1'b0;
        repeat (2) @(negedge clk);
        chk("irq pc", e_pc, pc);
        chk("irq ready", 12'h001, 12'(ready));
    endtask
    initial begin
        for (int a = 0; a < 4096; a++) u_mem.mem[a] = 12'($random(seed));
        e_pc = RST_PC;
        e_w = RST_BYTE;
        e_st = RST_STATUS;
        e_fsr = RST_BYTE;
        e_realtime_counter_reg = RST_BYTE;
        e_mode = RST_MODE;
        repeat (3) @(negedge clk);
        rst = 1'b0;
        chk("reset status", 12'(RST_STATUS), 12'(st));
        chk("reset ready", 12'h001, 12'(ready));
        exec(OP_IDLE);
        exec(12'h015);
        exec(12'h01B);
        exec(12'h9A7);
        exec(12'h012);
        exec(OP_XPAGE_EXIT);
        exec(12'hB3C);
        exec(12'h9F0);
        exec(12'h85C);
        exec(OP_TABLE_FETCH);
        exec(OP_MOV_PC_W);
        exec(OP_ADD_PC_W);
        exec(12'h4E2);
        exec(12'h503);
        exec(12'h403);
        exec(12'h503);
        exec(12'h703);
        exec(12'h403);
        exec(12'h703);
        exec(e_pc[0] ? 12'h702 : 12'h602);
        exec(12'h9C1);
        exec(OP_SUB_EXIT);
        $display("test corners done");
        // a low enable must hold every register, the watchdog included
        ce = 1'b0;
        valid = 1'b1;
        wdt_hold = wdt;
        repeat (3) @(negedge clk);
        chk("ce freeze pc", e_pc, pc);
        chk("ce freeze wdt", 12'(wdt_hold), 12'(wdt));
        ce = 1'b1;
        valid = 1'b0;
        @(negedge clk);
        irq_enter();
        exec(12'h944);
        exec(12'h8E7);
        exec(12'h01F);
        exec(12'h013);
        sleep_wake(1'b1);
        exec(OP_IRQ_EXIT);
        irq_enter();
        exec(12'h9D2);
        exec(12'h839);
        exec(OP_IRQ_EXIT_TA);
        sleep_wake(1'b0);
        $display("test irq done");
        for (int i = 0; i < 80; i++) begin
            logic [11:0] r;
            r = 12'($random(seed));
            case (r[2:0])
                3'h0: exec({OP_PAGE_HI, r[5:3]});
                3'h1: exec({OP_BANK_HI, r[5:3]});
                3'h2: begin
                    exec({OP_CALL_HI, r[11:4]});
                    exec({OP_LIT_EXIT_HI, r[10:3]});
                end
                3'h3: exec({OP_BRANCH_HI, r[11:3]});
                3'h4: exec({3'h2, r[3], 1'b0, r[4], 1'b0, FA_STATUS});
                3'h5: exec({3'h3, r[3], 1'b0, r[4], 1'b0, FA_STATUS});
                3'h6: exec({3'h3, r[3], r[6:4], FA_PC});
                default: exec(r[3] ? OP_TABLE_FETCH : OP_MOV_PC_W);
            endcase
        end
        $display("test random done");
        print_verdict();
    end
    initial begin
        repeat (5000) @(posedge clk);
        bad_count++;
        print_verdict();
    end
endmodule

// >>> tb/psd_imem_model.sv
// instruction memory model: opcode words at the fetch address, table words
// assumes the bench fills mem directly and owns the valid level
module psd_imem_model (
    input wire logic i_clk,
    input wire logic [11:0] i_addr,
    input wire logic i_valid,
    input wire logic i_table_req,
    input wire logic [11:0] i_table_addr,
    output logic [11:0] o_instr,
    output logic o_instr_valid,
    output logic [11:0] o_table_data
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [11:0] mem [0:4095];
    logic hold_ff = 1'b0;
    logic [11:0] junk_ff = 12'h3C3;
    always_ff @(posedge i_clk) begin
        hold_ff <= i_table_req;
        junk_ff <= ~junk_ff ^ 12'h5A5;
    end
    // released lines churn so a stale word can never pass for a real one
    assign o_instr_valid = i_valid;
    assign o_instr = i_valid ? mem[i_addr] : junk_ff;
    assign o_table_data = (i_table_req | hold_ff) ?
        mem[i_table_addr] : junk_ff;
endmodule
